// ---- hw/rps_sequencer.sv ----
// module: three-stage rail power sequencer with mcu reset release
// Overview of operation
// (RULE1) stages: pre buck, then post buck and boost, then external enables
// (RULE2) next rail enabled only when previous rail lies within uv and ov band
// (RULE3) sequence reruns whenever rails are enabled or disabled, e.g. entering active
// (RULE4) rails flagged unused are skipped, the following stage proceeds
// (RULE5) advance needs rail above uv threshold and rise time elapsed
// (RULE6) rise times 320 us per buck rail, 640 us for boost rail
// (RULE7) start-up interval of 300 us before sequencing starts
// (RULE8) uv monitor armed on enable, reported only after first threshold crossing
// (RULE9) short-to-ground time is sequencing timeout, late rail raises fault event
// (RULE10) on timeout either go to fault state or keep sequencing, per config
// (RULE11) ov monitoring active immediately when rail is enabled
// (RULE12) mcu reset released after mcu supply in band for selected delay
// (RULE13) external regulator on channel a must rise faster than its timeout
// (RULE14) middle stage rails enabled together, both must qualify before next
`timescale 1ns/1ps
module rps_sequencer (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    active_i,
    input  wire rps_pkg::rps_rails_t     rail_req_i,
    input  wire rps_pkg::rps_rails_t     rail_unused_i,
    input  wire rps_pkg::rps_mon_s       mon_i,
    input  wire logic                    mcu_supply_ok_i,
    input  wire logic [rps_pkg::DEL_W-1:0] reset_release_delay_sel_i,
    input  wire logic                    stg_to_fault_i,
    output rps_pkg::rps_out_s            rail_o,
    output logic                         mcu_reset_out_n_o,
    output logic                         seq_done_o,
    output logic                         fault_o
);
    import rps_pkg::*;

    // active, monitor and mcu supply inputs pass two flops before use
    logic       act_s1_ff, act_s2_ff;
    rps_mon_s   mon_s1_ff, mon_s2_ff;
    logic       sup_s1_ff, sup_s2_ff;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            act_s1_ff <= 1'b0;
            act_s2_ff <= 1'b0;
            mon_s1_ff <= '0;
            mon_s2_ff <= '0;
            sup_s1_ff <= 1'b0;
            sup_s2_ff <= 1'b0;
        end else begin
            act_s1_ff <= active_i;
            act_s2_ff <= act_s1_ff;
            mon_s1_ff <= mon_i;
            mon_s2_ff <= mon_s1_ff;
            sup_s1_ff <= mcu_supply_ok_i;
            sup_s2_ff <= sup_s1_ff;
        end
    end

    rps_state_e       state_ff, nxt_state;
    rps_rails_t       en_ff, nxt_en;
    rps_rails_t       req_ff;
    logic [TMR_W-1:0] st_tmr_ff, nxt_st_tmr;
    rps_rails_t       ok, uv_evt, ov_evt, stg_evt, want;
    logic             req_chg;

    // a disabled rail must not count as ready unless skipped as unused or not requested
    assign want    = act_s2_ff ? (rail_req_i & ~rail_unused_i) : '0;
    assign req_chg = (want != req_ff);

    localparam logic [TMR_W-1:0] RISE_TAB [N_RAIL] = '{
        TMR_W'(BUCK_RISE_CYC), TMR_W'(BUCK_RISE_CYC), TMR_W'(BOOST_RISE_CYC), '0, '0
    };

    // (RULE6) rise time per rail
    genvar gi;
    generate
        for (gi = 0; gi < N_RAIL; gi++) begin : g_mon
            rps_rail_mon #(
                .RISE_CYC (RISE_TAB[gi])
            ) u_mon (
                .mclk_i     (mclk_i),
                .reset_n_i  (reset_n_i),
                .en_i       (en_ff[gi]),
                .above_uv_i (mon_s2_ff.above_uv[gi]),
                .above_ov_i (mon_s2_ff.above_ov[gi]),
                .ok_o       (ok[gi]),
                .uv_evt_o   (uv_evt[gi]),
                .ov_evt_o   (ov_evt[gi]),
                .stg_evt_o  (stg_evt[gi])
            );
        end
    endgenerate

    // (RULE4) skipped rails count as qualified
    logic pre_done, post_done;
    assign pre_done  = ok[IDX_PRE] || !want[IDX_PRE];
    assign post_done = (ok[IDX_PBUCK] || !want[IDX_PBUCK]) && (ok[IDX_BOOST] || !want[IDX_BOOST]);

    always_comb begin
        nxt_state  = state_ff;
        nxt_en     = en_ff;
        nxt_st_tmr = st_tmr_ff;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_en = '0;
                // (RULE3) sequence starts on activation
                if (|want) begin
                    nxt_state  = ST_STARTUP;
                    nxt_st_tmr = '0;
                end
            end
            ST_STARTUP: begin
                nxt_st_tmr = st_tmr_ff + 1'b1;
                // (RULE7) start-up wait
                if (st_tmr_ff >= TMR_W'(STARTUP_CYC - 1)) begin
                    nxt_state = ST_PRE;
                end
            end
            ST_PRE: begin
                // (RULE1) first stage
                nxt_en[IDX_PRE] = want[IDX_PRE];
                // (RULE2) band gated advance
                if (en_ff[IDX_PRE] == want[IDX_PRE] && pre_done) begin
                    nxt_state = ST_POST;
                end
            end
            ST_POST: begin
                // (RULE14) middle pair together
                nxt_en[IDX_PBUCK] = want[IDX_PBUCK];
                nxt_en[IDX_BOOST] = want[IDX_BOOST];
                if (en_ff[IDX_BOOST:IDX_PBUCK] == want[IDX_BOOST:IDX_PBUCK] && post_done) begin
                    nxt_state = ST_EXT;
                end
            end
            ST_EXT: begin
                nxt_en[IDX_CHA] = want[IDX_CHA];
                nxt_en[IDX_CHB] = want[IDX_CHB];
            end
            ST_FAULT: begin
                nxt_en = '0;
                if (!act_s2_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
        // (RULE3) rerun on an enable change in the pre, post or ext stage
        // a change during start-up must not cut the start-up wait short
        if (state_ff != ST_FAULT && state_ff != ST_IDLE && state_ff != ST_STARTUP && req_chg) begin
            nxt_state = ST_PRE;
            nxt_en    = en_ff & want;
        end
        if (state_ff != ST_FAULT && state_ff != ST_IDLE && !act_s2_ff) begin
            nxt_state = ST_IDLE;
            nxt_en    = '0;
        end
        // (RULE10) configured timeout response
        if (stg_to_fault_i && (|stg_evt)) begin
            nxt_state = ST_FAULT;
            nxt_en    = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_ff  <= ST_IDLE;
            en_ff     <= '0;
            st_tmr_ff <= '0;
            req_ff    <= '0;
        end else begin
            state_ff  <= nxt_state;
            en_ff     <= nxt_en;
            st_tmr_ff <= nxt_st_tmr;
            req_ff    <= want;
        end
    end

    // reset release delay and registered outputs
    logic [TMR_W+DEL_W:0] rst_tmr_ff, nxt_rst_tmr;
    logic [TMR_W+DEL_W:0] rst_lim;
    logic                 rot_ff, nxt_rot;
    rps_out_s             out_ff, nxt_out;
    logic                 done_ff, fault_ff;

    assign rst_lim = (TMR_W + DEL_W + 1)'(RESET_RELEASE_DELAY_SEL_UNIT_CYC) * ({1'b0, reset_release_delay_sel_i} + 1'b1);

    always_comb begin
        nxt_rst_tmr = '0;
        nxt_rot     = 1'b0;
        // (RULE12) supply must hold in band for the delay
        if (sup_s2_ff && state_ff != ST_FAULT) begin
            nxt_rst_tmr = rst_tmr_ff;
            if (rst_tmr_ff >= rst_lim - 1'b1) begin
                nxt_rot = 1'b1;
            end else begin
                nxt_rst_tmr = rst_tmr_ff + 1'b1;
            end
        end
        nxt_out.en      = nxt_en;
        nxt_out.uv_evt  = uv_evt;
        nxt_out.ov_evt  = ov_evt;
        nxt_out.stg_evt = stg_evt;
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rst_tmr_ff <= '0;
            rot_ff     <= 1'b0;
            out_ff     <= '0;
            done_ff    <= 1'b0;
            fault_ff   <= 1'b0;
        end else begin
            rst_tmr_ff <= nxt_rst_tmr;
            rot_ff     <= nxt_rot;
            out_ff     <= nxt_out;
            done_ff    <= (nxt_state == ST_EXT);
            fault_ff   <= (nxt_state == ST_FAULT);
        end
    end

    assign rail_o            = out_ff;
    assign mcu_reset_out_n_o = rot_ff;
    assign seq_done_o        = done_ff;
    assign fault_o           = fault_ff;
endmodule

// ---- hw/rps_pkg.sv ----
// package: constants, states and carrier structs for the rail power sequencer
package rps_pkg;

    localparam int unsigned CLK_MHZ         = 100;
    // times in microseconds, as printed
    localparam int unsigned STARTUP_US      = 300;
    localparam int unsigned BUCK_RISE_US    = 320;
    localparam int unsigned BOOST_RISE_US   = 640;
    localparam int unsigned STG_US          = 100;    // short-to-ground detection time, plain default
    localparam int unsigned RESET_RELEASE_DELAY_SEL_UNIT_US  = 100;    // reset delay step per code, plain default

    localparam int unsigned STARTUP_CYC     = STARTUP_US * CLK_MHZ;
    localparam int unsigned BUCK_RISE_CYC   = BUCK_RISE_US * CLK_MHZ;
    localparam int unsigned BOOST_RISE_CYC  = BOOST_RISE_US * CLK_MHZ;
    localparam int unsigned STG_CYC         = STG_US * CLK_MHZ;
    localparam int unsigned RESET_RELEASE_DELAY_SEL_UNIT_CYC = RESET_RELEASE_DELAY_SEL_UNIT_US * CLK_MHZ;

    localparam int unsigned TMR_W  = 24;
    localparam int unsigned DEL_W  = 2;
    localparam int unsigned N_RAIL = 5;

    // rail index positions in all per-rail vectors
    localparam int unsigned IDX_PRE   = 0;
    localparam int unsigned IDX_PBUCK = 1;
    localparam int unsigned IDX_BOOST = 2;
    localparam int unsigned IDX_CHA   = 3;
    localparam int unsigned IDX_CHB   = 4;

    typedef logic [N_RAIL-1:0] rps_rails_t;

    // per-rail monitor comparator levels
    typedef struct packed {
        rps_rails_t above_uv;
        rps_rails_t above_ov;
    } rps_mon_s;

    // per-rail enables and fault events
    typedef struct packed {
        rps_rails_t en;
        rps_rails_t uv_evt;
        rps_rails_t ov_evt;
        rps_rails_t stg_evt;
    } rps_out_s;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_STARTUP = 6'h02,
        ST_PRE     = 6'h04,
        ST_POST    = 6'h08,
        ST_EXT     = 6'h10,
        ST_FAULT   = 6'h20
    } rps_state_e;

endpackage

// ---- hw/rps_rail_mon.sv ----
// module: per-rail uv/ov/short-to-ground monitor with rise-time timer
`timescale 1ns/1ps
module rps_rail_mon #(
    parameter logic [rps_pkg::TMR_W-1:0] RISE_CYC = '0
) (
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    input  wire logic en_i,
    input  wire logic above_uv_i,
    input  wire logic above_ov_i,
    output logic      ok_o,
    output logic      uv_evt_o,
    output logic      ov_evt_o,
    output logic      stg_evt_o
);
    import rps_pkg::*;

    logic [TMR_W-1:0] tmr_ff, nxt_tmr;
    logic             crossed_ff, nxt_crossed;
    logic             stg_done_ff, nxt_stg_done;
    logic             uv_ff, nxt_uv;
    logic             ov_ff, nxt_ov;
    logic             stg_ff, nxt_stg;
    logic             in_band;

    assign in_band = above_uv_i && !above_ov_i;

    always_comb begin
        nxt_tmr      = tmr_ff;
        nxt_crossed  = crossed_ff;
        nxt_stg_done = stg_done_ff;
        nxt_uv       = 1'b0;
        nxt_ov       = 1'b0;
        nxt_stg      = 1'b0;
        if (!en_i) begin
            nxt_tmr      = '0;
            nxt_crossed  = 1'b0;
            nxt_stg_done = 1'b0;
        end else begin
            if (tmr_ff != {TMR_W{1'b1}}) begin
                nxt_tmr = tmr_ff + 1'b1;
            end
            // (RULE8) uv reported after first crossing
            if (above_uv_i) begin
                nxt_crossed = 1'b1;
            end
            nxt_uv = crossed_ff && !above_uv_i;
            // (RULE11) ov watched from enable
            nxt_ov = above_ov_i;
            // (RULE9) late rail times out
            if (!crossed_ff && !stg_done_ff && tmr_ff >= TMR_W'(STG_CYC)) begin
                nxt_stg      = 1'b1;
                nxt_stg_done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            tmr_ff      <= '0;
            crossed_ff  <= 1'b0;
            stg_done_ff <= 1'b0;
            uv_ff       <= 1'b0;
            ov_ff       <= 1'b0;
            stg_ff      <= 1'b0;
        end else begin
            tmr_ff      <= nxt_tmr;
            crossed_ff  <= nxt_crossed;
            stg_done_ff <= nxt_stg_done;
            uv_ff       <= nxt_uv;
            ov_ff       <= nxt_ov;
            stg_ff      <= nxt_stg;
        end
    end

    // (RULE5) in band and rise time both needed
    assign ok_o      = en_i && in_band && (tmr_ff >= RISE_CYC);
    assign uv_evt_o  = uv_ff;
    assign ov_evt_o  = ov_ff;
    assign stg_evt_o = stg_ff;
endmodule

// ---- tb/rps_sequencer_monitor.sv ----
// checker: stage order, rise times, reset release and fault behaviour
`timescale 1ns/1ps
module rps_sequencer_monitor import rps_pkg::*; (
    input wire logic                      mclk_i,
    input wire logic                      reset_n_i,
    input wire logic                      active_i,
    input wire rps_pkg::rps_rails_t       rail_req_i,
    input wire rps_pkg::rps_rails_t       rail_unused_i,
    input wire rps_pkg::rps_mon_s         mon_i,
    input wire logic                      mcu_supply_ok_i,
    input wire logic [rps_pkg::DEL_W-1:0] reset_release_delay_sel_i,
    input wire logic                      stg_to_fault_i,
    input wire rps_pkg::rps_out_s         rail_o,
    input wire logic                      mcu_reset_out_n_o,
    input wire logic                      seq_done_o,
    input wire logic                      fault_o
);
    int unsigned pre_cnt;
    int unsigned bst_cnt;
    int unsigned act_cnt;
    int unsigned sup_cnt;
    rps_rails_t  seen;
    // raw inputs lead the design's synchronised copies, so these bounds stay safe
    always_ff @(posedge mclk_i) begin
        pre_cnt <= (reset_n_i && rail_o.en[0]) ? pre_cnt + 1 : 0;
        bst_cnt <= (reset_n_i && rail_o.en[2]) ? bst_cnt + 1 : 0;
        act_cnt <= (reset_n_i && active_i) ? act_cnt + 1 : 0;
        sup_cnt <= (reset_n_i && mcu_supply_ok_i) ? sup_cnt + 1 : 0;
        seen    <= reset_n_i ? rail_o.en & (seen | mon_i.above_uv) : '0;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_ov_held;
        (rail_o.en[0] && mon_i.above_ov[0]) [*5];
    endsequence
    sequence s_post_start;
        $rose(rail_o.en[1]) && rail_req_i[0] && !rail_unused_i[0];
    endsequence
    a_unused_off: assert property (
        (rail_o.en & rail_unused_i & $past(rail_unused_i)) == '0) else $error("unused rail enabled");
    a_startup_wait: assert property (
        $rose(rail_o.en[0]) |-> act_cnt >= STARTUP_CYC) else $error("pre rail before start-up time");
    a_post_rise: assert property (
        s_post_start |-> pre_cnt >= BUCK_RISE_CYC) else $error("post stage before pre rise time");
    a_post_pair: assert property (
        (s_post_start and (rail_req_i[2] && !rail_unused_i[2])) |-> rail_o.en[2])
        else $error("post rails split");
    a_boost_rise: assert property (
        $rose(rail_o.en[3]) && rail_o.en[2] |-> bst_cnt >= BOOST_RISE_CYC) else $error("ext before boost rise");
    a_reset_delay: assert property (
        $rose(mcu_reset_out_n_o) |-> sup_cnt >= (reset_release_delay_sel_i + 1) * RESET_RELEASE_DELAY_SEL_UNIT_CYC)
        else $error("mcu reset released early");
    a_fault_off: assert property (
        fault_o && $past(fault_o) |-> rail_o.en == '0) else $error("rail on in fault");
    a_ov_armed: assert property (
        s_ov_held |-> rail_o.ov_evt[0]) else $error("ov not reported");
    a_uv_masked: assert property (
        (rail_o.uv_evt & ~(seen | $past(seen))) == '0) else $error("uv before first crossing");
endmodule
bind rps_sequencer rps_sequencer_monitor mon_u (
    .mclk_i, .reset_n_i, .active_i, .rail_req_i, .rail_unused_i, .mon_i, .mcu_supply_ok_i,
    .reset_release_delay_sel_i, .stg_to_fault_i, .rail_o, .mcu_reset_out_n_o, .seq_done_o, .fault_o
);

// ---- tb/rps_rail_model.sv ----
// partner model: rails that come into band a fixed time after their enable
`timescale 1ns/1ps
module rps_rail_model #(
    parameter int RISE_CYC = 500
) (
    input  wire logic                mclk_i,
    input  wire rps_pkg::rps_rails_t en_i,
    input  wire rps_pkg::rps_rails_t dead_i,
    input  wire rps_pkg::rps_rails_t ovf_i,
    output rps_pkg::rps_mon_s        mon_o
);
    import rps_pkg::*;
    int cnt [N_RAIL];
    initial mon_o = '0;
    // a live rail settles far inside the timeout
    always @(posedge mclk_i) begin
        for (int i = 0; i < N_RAIL; i++) begin
            cnt[i] <= en_i[i] ? cnt[i] + 1 : 0;
            mon_o.above_uv[i] <= en_i[i] && !dead_i[i] && cnt[i] >= RISE_CYC;
            mon_o.above_ov[i] <= en_i[i] && ovf_i[i];
        end
    end
endmodule

// ---- tb/rail_power_sequencer_test.sv ----
// testbench: full sequence, skipped stages and short-to-ground timeout
`timescale 1ns/1ps
module rail_power_sequencer_test;
    import rps_pkg::*;
    logic             mclk_i;
    logic             reset_n_i;
    logic             active_i;
    rps_rails_t       rail_req_i;
    rps_rails_t       rail_unused_i;
    rps_rails_t       dead;
    rps_rails_t       ovf;
    rps_mon_s         mon_i;
    logic             mcu_supply_ok_i;
    logic [DEL_W-1:0] reset_release_delay_sel_i;
    logic             stg_to_fault_i;
    rps_out_s         rail_o;
    logic             mcu_reset_out_n_o;
    logic             seq_done_o;
    logic             fault_o;
    logic [11:0]      obs;
    int               err_count;
    int               tests_run;
    int               n;
    assign obs = {rail_o.stg_evt, mcu_reset_out_n_o, fault_o, rail_o.en};
    rps_sequencer dut_u (
        .mclk_i, .reset_n_i, .active_i, .rail_req_i, .rail_unused_i, .mon_i, .mcu_supply_ok_i,
        .reset_release_delay_sel_i, .stg_to_fault_i, .rail_o, .mcu_reset_out_n_o, .seq_done_o, .fault_o
    );
    rps_rail_model model_u (.mclk_i, .en_i(rail_o.en), .dead_i(dead), .ovf_i(ovf), .mon_o(mon_i));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic near(input string nm, input int v, input int lo);
        check(nm, 32'(v >= lo && v <= lo + 8), 32'h1);
    endtask
    task automatic close_out();
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // counts cycles until an observed bit rises; running out ends the run
    task automatic wait_bit(input int b, input int lim);
        n = 0;
        while (obs[b] !== 1'b1) begin
            @(negedge mclk_i);
            n++;
            if (n > lim) begin
                err_count++;
                close_out();
            end
        end
    endtask
    task automatic seq_full();
        @(posedge mclk_i);
        active_i        <= 1'b1;
        rail_req_i      <= 5'h1f;
        mcu_supply_ok_i <= 1'b1;
        wait_bit(0, 40000);
        near("pre delay", n, STARTUP_CYC);
        check("pre alone", rail_o.en, 5'h01);
        check("reset held", mcu_reset_out_n_o, 1'b0);
        wait_bit(1, 40000);
        near("post delay", n, BUCK_RISE_CYC);
        check("post pair", rail_o.en, 5'h07);
        wait_bit(3, 70000);
        near("ext delay", n, BOOST_RISE_CYC);
        check("ext pair", rail_o.en, 5'h1f);
        check("done", seq_done_o, 1'b1);
        check("reset free", mcu_reset_out_n_o, 1'b1);
        check("no uv", rail_o.uv_evt, 5'h00);
        @(posedge mclk_i);
        ovf        <= 5'h01;
        rail_req_i <= 5'h0f;
        repeat (8) @(negedge mclk_i);
        check("ov", rail_o.ov_evt, 5'h01);
        check("drop b", rail_o.en, 5'h0f);
        @(posedge mclk_i);
        ovf        <= 5'h00;
        rail_req_i <= 5'h1f;
        wait_bit(4, 40000);
        check("b again", rail_o.en, 5'h1f);
        @(posedge mclk_i);
        dead <= 5'h01;
        repeat (6) @(negedge mclk_i);
        check("uv pre", rail_o.uv_evt, 5'h01);
        @(posedge mclk_i);
        mcu_supply_ok_i <= 1'b0;
        repeat (6) @(negedge mclk_i);
        check("reset back", mcu_reset_out_n_o, 1'b0);
    endtask
    task automatic seq_skip();
        @(posedge mclk_i);
        active_i <= 1'b0;
        repeat (8) @(negedge mclk_i);
        check("inactive", rail_o.en, 5'h00);
        @(posedge mclk_i);
        rail_unused_i  <= 5'h07;
        dead           <= 5'h08;
        stg_to_fault_i <= 1'b0;
        active_i       <= 1'b1;
        wait_bit(3, 40000);
        near("skip delay", n, STARTUP_CYC);
        check("skipped", rail_o.en, 5'h18);
        wait_bit(10, STG_CYC + 100);
        near("stg time", n, STG_CYC);
        check("uv masked", rail_o.uv_evt, 5'h00);
        repeat (4) @(negedge mclk_i);
        check("stg go on", {fault_o, rail_o.en}, 6'h18);
        // re-enable the dead rail so its timeout runs again, now with the fault response
        @(posedge mclk_i);
        stg_to_fault_i <= 1'b1;
        rail_req_i     <= 5'h17;
        repeat (4) @(negedge mclk_i);
        check("drop a", rail_o.en, 5'h10);
        @(posedge mclk_i);
        rail_req_i <= 5'h1f;
        wait_bit(10, STG_CYC + 100);
        near("stg again", n, STG_CYC + 4);
        repeat (4) @(negedge mclk_i);
        check("fault", fault_o, 1'b1);
        check("fault off", rail_o.en, 5'h00);
        @(posedge mclk_i);
        active_i <= 1'b0;
        repeat (6) @(negedge mclk_i);
        check("fault clear", fault_o, 1'b0);
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        reset_n_i                 = 1'b0;
        active_i                  = 1'b0;
        rail_req_i                = 5'h00;
        rail_unused_i             = 5'h00;
        dead                      = 5'h00;
        ovf                       = 5'h00;
        mcu_supply_ok_i           = 1'b0;
        reset_release_delay_sel_i = 2'h3;
        stg_to_fault_i            = 1'b1;
        err_count                 = 0;
        tests_run                 = 0;
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        seq_full();
        seq_skip();
        close_out();
    end
endmodule
